/* fur_loader.sv */
// fuse and customer data row storage with the start-up copy into targets
// assumes cpu and program_debug_port requests come from logic on REF_CLK
//
// Behaviour
// - 32-byte customer data row survives chip erase
// - debug port may write row while locked
// - debug port row reads refused while locked
// - cpu reads and writes row freely
// - cpu reads fuses, debug port reads them only while unlocked; only debug port programs
// - copy every fuse into targets at start-up
// - new fuse values act only after reset
// - fuse bytes survive chip erase
// - watchdog window from fuse bits 7:4
// - watchdog period from fuse bits 3:0
// - brownout threshold from fuse bits 7:5
// - brownout sample rate from bit 4
// - brownout active mode from bits 3:2
// - brownout sleep mode from bits 1:0
// - default oscillator from oscillator fuse
`timescale 1ns/10ps
module fur_loader
    import fur_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic LOCKED,
    input wire fur_req_t CPU_REQ,
    output fur_rsp_t CPU_RSP,
    input wire fur_req_t DBG_REQ,
    output fur_rsp_t DBG_RSP,
    output fur_targets_t TARGETS,
    output logic EXEC_RELEASE,
    output logic CFG_RESERVED
);

    fur_state_t state_q;
    logic [3:0] idx_q;
    logic [7:0] fuse_mem [FUSE_BYTES];
    logic [7:0] row_mem [ROW_BYTES];
    fur_targets_t targets_q;
    fur_rsp_t cpu_rsp_q;
    fur_rsp_t dbg_rsp_q;
    logic rsvd_q;
    logic run;
    logic loading;
    logic cpu_ref;
    logic dbg_ref;
    logic cpu_go;
    logic dbg_go;
    logic [7:0] fuse_wdog;
    logic [7:0] fuse_bo;
    logic [7:0] fuse_osc;

    function automatic logic fuse_addr_ok(input logic [4:0] a);
        return (a <= {1'h0, FUSE_OFS_LAST}) && (a[3:0] != FUSE_OFS_RSVD_LO)
            && (a[3:0] != FUSE_OFS_RSVD_HI);
    endfunction

    function automatic logic is_refused(input fur_req_t r, input logic ext,
                                        input logic locked);
        if (r.row) begin
            return ext && locked && !r.we;
        end
        if (!fuse_addr_ok(r.addr)) begin
            return 1'h1;
        end
        if (r.we) begin
            return !ext;
        end
        // a locked part hides fuse data from the debug port as well
        return ext && locked;
    endfunction

    function automatic logic [7:0] read_byte(input fur_req_t r);
        if (r.row) begin
            return row_mem[r.addr];
        end
        return fuse_mem[r.addr[3:0]];
    endfunction

    assign run = (state_q == ST_RUN);
    assign loading = (state_q == ST_LOAD);
    assign cpu_ref = is_refused(CPU_REQ, 1'h0, LOCKED);
    assign dbg_ref = is_refused(DBG_REQ, 1'h1, LOCKED);
    // requests during the copy are dropped, not held; nothing is answered before release
    assign cpu_go = CE && run && CPU_REQ.valid && !cpu_ref;
    assign dbg_go = CE && run && DBG_REQ.valid && !dbg_ref;
    assign fuse_wdog = fuse_mem[FUSE_OFS_WDOG];
    assign fuse_bo = fuse_mem[FUSE_OFS_BROWNOUT];
    assign fuse_osc = fuse_mem[FUSE_OFS_OSC];

    // start-up sequencer: one fuse byte per enabled cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_LOAD;
            idx_q <= 4'h0;
        end else if (CE && loading) begin
            if (idx_q == FUSE_OFS_LAST) begin
                state_q <= ST_RUN;
            end
            idx_q <= idx_q + 4'h1;
        end
    end

    // target copy; frozen once running so new fuses wait for reset
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            targets_q <= '0;
        end else if (CE && loading) begin
            case (idx_q)
                FUSE_OFS_WDOG: begin
                    targets_q.wdog_window <= fuse_wdog[WDOG_WINDOW_LSB +: 4];
                    targets_q.wdog_period <= fuse_wdog[WDOG_PERIOD_LSB +: 4];
                end
                FUSE_OFS_BROWNOUT: begin
                    targets_q.brownout_threshold_sel <= fuse_bo[BO_THRESH_LSB +: 3];
                    targets_q.brownout_sample_rate_sel <= fuse_bo[BO_RATE_BIT];
                    targets_q.brownout_active_mode <= fuse_bo[BO_ACTIVE_LSB +: 2];
                    targets_q.brownout_sleep_mode <= fuse_bo[BO_SLEEP_LSB +: 2];
                end
                FUSE_OFS_OSC: begin
                    targets_q.default_osc_choice <= fuse_osc[OSC_CHOICE_LSB +: 4];
                end
                FUSE_OFS_SYS0: begin
                    targets_q.sys_cfg0 <= fuse_mem[FUSE_OFS_SYS0];
                end
                FUSE_OFS_SYS1: begin
                    targets_q.sys_cfg1 <= fuse_mem[FUSE_OFS_SYS1];
                end
                FUSE_OFS_CODE: begin
                    targets_q.code_size <= fuse_mem[FUSE_OFS_CODE];
                end
                FUSE_OFS_BOOT: begin
                    targets_q.boot_size <= fuse_mem[FUSE_OFS_BOOT];
                end
                default: begin
                end
            endcase
        end
    end

    // reserved codes are passed through unchanged but flagged
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rsvd_q <= 1'b0;
        end else if (CE && loading) begin
            case (idx_q)
                FUSE_OFS_BROWNOUT: begin
                    rsvd_q <= rsvd_q || (fuse_bo[BO_THRESH_LSB +: 3] > BO_THRESH_MAX)
                        || (fuse_bo[BO_SLEEP_LSB +: 2] == BO_SLEEP_RSVD);
                end
                FUSE_OFS_OSC: begin
                    rsvd_q <= rsvd_q
                        || (fuse_osc[OSC_CHOICE_LSB +: 4] > OSC_INTERNAL_SLOW_OSC);
                end
                default: begin
                end
            endcase
        end
    end

    // storage is nonvolatile: no reset, and no erase path reaches it
    always_ff @(posedge REF_CLK) begin
        if (cpu_go && CPU_REQ.we && CPU_REQ.row) begin
            row_mem[CPU_REQ.addr] <= CPU_REQ.wdata;
        end
        // debug port wins a same-byte collision by writing last
        if (dbg_go && DBG_REQ.we && DBG_REQ.row) begin
            row_mem[DBG_REQ.addr] <= DBG_REQ.wdata;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (dbg_go && DBG_REQ.we && !DBG_REQ.row) begin
            fuse_mem[DBG_REQ.addr[3:0]] <= DBG_REQ.wdata;
        end
    end

    // answers one enabled cycle after the request
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cpu_rsp_q <= '0;
        end else if (CE) begin
            cpu_rsp_q.ack <= cpu_go;
            cpu_rsp_q.err <= run && CPU_REQ.valid && cpu_ref;
            if (cpu_go && !CPU_REQ.we) begin
                cpu_rsp_q.rdata <= read_byte(CPU_REQ);
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            dbg_rsp_q <= '0;
        end else if (CE) begin
            dbg_rsp_q.ack <= dbg_go;
            dbg_rsp_q.err <= run && DBG_REQ.valid && dbg_ref;
            if (dbg_go && !DBG_REQ.we) begin
                dbg_rsp_q.rdata <= read_byte(DBG_REQ);
            end
        end
    end

    assign CPU_RSP = cpu_rsp_q;
    assign DBG_RSP = dbg_rsp_q;
    assign TARGETS = targets_q;
    assign EXEC_RELEASE = run;
    assign CFG_RESERVED = rsvd_q;

    // helper: enabled cycles since reset, saturating
    logic [4:0] ce_cnt_q;
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ce_cnt_q <= 5'h00;
        end else if (CE && (ce_cnt_q != 5'h1F)) begin
            ce_cnt_q <= ce_cnt_q + 5'h01;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    property p_row_write_locked;
        CE && run && LOCKED && DBG_REQ.valid && DBG_REQ.we && DBG_REQ.row
            |=> DBG_RSP.ack && !DBG_RSP.err;
    endproperty
    a_row_write_locked: assert property (p_row_write_locked) else $error("locked row write refused");

    property p_row_read_locked;
        CE && run && LOCKED && DBG_REQ.valid && !DBG_REQ.we && DBG_REQ.row
            |=> DBG_RSP.err && !DBG_RSP.ack;
    endproperty
    a_row_read_locked: assert property (p_row_read_locked) else $error("locked row read served");

    property p_cpu_row;
        CE && run && CPU_REQ.valid && CPU_REQ.row
            |=> CPU_RSP.ack && !CPU_RSP.err;
    endproperty
    a_cpu_row: assert property (p_cpu_row) else $error("cpu row access refused");

    property p_cpu_fuse_write;
        CE && run && CPU_REQ.valid && CPU_REQ.we && !CPU_REQ.row
            |=> CPU_RSP.err && !CPU_RSP.ack;
    endproperty
    a_cpu_fuse_write: assert property (p_cpu_fuse_write) else $error("cpu fuse write taken");

    property p_release_count;
        EXEC_RELEASE == (ce_cnt_q >= 5'(FUSE_BYTES));
    endproperty
    a_release_count: assert property (p_release_count) else $error("release not after copy");

    property p_hold_targets;
        run |=> $stable(TARGETS) && run;
    endproperty
    a_hold_targets: assert property (p_hold_targets) else $error("targets moved after start-up");

    property p_no_answer_loading;
        loading |=> !CPU_RSP.ack && !DBG_RSP.ack;
    endproperty
    a_no_answer_loading: assert property (p_no_answer_loading) else $error("answer during copy");

    // sampled RST keeps out the release edge, where the flops were still in reset
    // unprogrammed fuses copy as unknown, so the copy checks compare exactly
    property p_wdog_window;
        !RST && CE && loading && idx_q == FUSE_OFS_WDOG
            |=> TARGETS.wdog_window === $past(fuse_wdog[7:4]);
    endproperty
    a_wdog_window: assert property (p_wdog_window) else $error("window not copied");

    property p_wdog_period;
        !RST && CE && loading && idx_q == FUSE_OFS_WDOG
            |=> TARGETS.wdog_period === $past(fuse_wdog[3:0]);
    endproperty
    a_wdog_period: assert property (p_wdog_period) else $error("period not copied");

    property p_bo_thresh;
        !RST && CE && loading && idx_q == FUSE_OFS_BROWNOUT
            |=> TARGETS.brownout_threshold_sel === $past(fuse_bo[7:5]);
    endproperty
    a_bo_thresh: assert property (p_bo_thresh) else $error("threshold not copied");

    property p_bo_rate;
        !RST && CE && loading && idx_q == FUSE_OFS_BROWNOUT
            |=> TARGETS.brownout_sample_rate_sel === $past(fuse_bo[4]);
    endproperty
    a_bo_rate: assert property (p_bo_rate) else $error("sample rate not copied");

    property p_bo_active;
        !RST && CE && loading && idx_q == FUSE_OFS_BROWNOUT
            |=> TARGETS.brownout_active_mode === $past(fuse_bo[3:2]);
    endproperty
    a_bo_active: assert property (p_bo_active) else $error("active mode not copied");

    property p_bo_sleep;
        !RST && CE && loading && idx_q == FUSE_OFS_BROWNOUT
            |=> TARGETS.brownout_sleep_mode === $past(fuse_bo[1:0]);
    endproperty
    a_bo_sleep: assert property (p_bo_sleep) else $error("sleep mode not copied");

    property p_osc;
        !RST && CE && loading && idx_q == FUSE_OFS_OSC
            |=> TARGETS.default_osc_choice === $past(fuse_osc[3:0]);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator choice not copied");

    property p_dbg_fuse_program;
        CE && run && !LOCKED && DBG_REQ.valid && DBG_REQ.we && !DBG_REQ.row
            && fuse_addr_ok(DBG_REQ.addr) |=> DBG_RSP.ack ##1 CE [*1] ##0 run;
    endproperty
    a_dbg_fuse_program: assert property (p_dbg_fuse_program) else $error("fuse program refused");

    property p_c_release;
        $rose(EXEC_RELEASE);
    endproperty
    c_release: cover property (p_c_release);

    property p_c_locked_row_write;
        LOCKED && DBG_RSP.ack ##1 CPU_RSP.ack;
    endproperty
    c_locked_row_write: cover property (p_c_locked_row_write);

    property p_c_cpu_refused;
        CPU_RSP.err ##1 CPU_RSP.ack;
    endproperty
    c_cpu_refused: cover property (p_c_cpu_refused);

endmodule

/* fur_pkg.sv */
// fuse and customer data row loader: constants and carrier types
// assumes one clock domain; fuse and row storage live in the loader itself
package fur_pkg;

    localparam int FUSE_BYTES = 9;
    localparam int ROW_BYTES = 32;

    // fuse byte offsets
    localparam logic [3:0] FUSE_OFS_WDOG = 4'h0;
    localparam logic [3:0] FUSE_OFS_BROWNOUT = 4'h1;
    localparam logic [3:0] FUSE_OFS_OSC = 4'h2;
    localparam logic [3:0] FUSE_OFS_RSVD_LO = 4'h3;
    localparam logic [3:0] FUSE_OFS_RSVD_HI = 4'h4;
    localparam logic [3:0] FUSE_OFS_SYS0 = 4'h5;
    localparam logic [3:0] FUSE_OFS_SYS1 = 4'h6;
    localparam logic [3:0] FUSE_OFS_CODE = 4'h7;
    localparam logic [3:0] FUSE_OFS_BOOT = 4'h8;
    localparam logic [3:0] FUSE_OFS_LAST = 4'h8;

    // field positions
    localparam int WDOG_WINDOW_LSB = 4;
    localparam int WDOG_PERIOD_LSB = 0;
    localparam int BO_THRESH_LSB = 5;
    localparam int BO_RATE_BIT = 4;
    localparam int BO_ACTIVE_LSB = 2;
    localparam int BO_SLEEP_LSB = 0;
    localparam int OSC_CHOICE_LSB = 0;

    // field codes
    localparam logic [2:0] BO_THRESH_MAX = 3'h3;
    localparam logic BO_RATE_128HZ = 1'h0;
    localparam logic BO_RATE_32HZ = 1'h1;
    localparam logic [1:0] BO_MODE_OFF = 2'h0;
    localparam logic [1:0] BO_MODE_CONT = 2'h1;
    localparam logic [1:0] BO_MODE_SAMPLED = 2'h2;
    localparam logic [1:0] BO_MODE_CONTINUOUS_HOLD_WAKE = 2'h3;
    localparam logic [1:0] BO_SLEEP_RSVD = 2'h3;
    localparam logic [3:0] OSC_INTERNAL_FAST_OSC = 4'h0;
    localparam logic [3:0] OSC_INTERNAL_SLOW_OSC = 4'h1;

    typedef enum logic {
        ST_LOAD,
        ST_RUN
    } fur_state_t;

    // row = 1 selects the customer data row, 0 the fuse bytes
    typedef struct packed {
        logic valid;
        logic we;
        logic row;
        logic [4:0] addr;
        logic [7:0] wdata;
    } fur_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [7:0] rdata;
    } fur_rsp_t;

    typedef struct packed {
        logic [3:0] wdog_window;
        logic [3:0] wdog_period;
        logic [2:0] brownout_threshold_sel;
        logic brownout_sample_rate_sel;
        logic [1:0] brownout_active_mode;
        logic [1:0] brownout_sleep_mode;
        logic [3:0] default_osc_choice;
        logic [7:0] sys_cfg0;
        logic [7:0] sys_cfg1;
        logic [7:0] code_size;
        logic [7:0] boot_size;
    } fur_targets_t;

endpackage

/* fur_prog_model.sv */
// programmer model for the program_debug_port, one byte per request
// assumes requests start only while EXEC_RELEASE is high
`timescale 1ns/10ps
module fur_prog_model
    import fur_pkg::*;
(
    input wire logic clk,
    input wire fur_rsp_t rsp,
    output fur_req_t req
);
    initial req = '0;

    // gap idles first so the loader also sees slow callers
    task automatic access(input logic we, input logic row, input logic [4:0] a,
                          input logic [7:0] d, input int gap,
                          output logic [1:0] ae, output logic [7:0] rd);
        repeat (gap) @(posedge clk);
        if (we && !row && a == 5'h02)
            d = d & 8'h0F;
        if (we && !row && a == 5'h05)
            d = d & 8'hE9;
        if (we && !row && a == 5'h06)
            d = d & 8'h1F;
        @(posedge clk);
        req <= '{1'h1, we, row, a, d};
        @(posedge clk);
        // released fields flip so stale values never look valid
        req <= '{1'h0, ~we, ~row, ~a, ~d};
        #1;
        ae = {rsp.ack, rsp.err};
        rd = rsp.rdata;
    endtask
endmodule

/* fur_loader_tb_top.sv */
// loader bench: two programmer models as callers, reference arrays
// assumes answers one enabled cycle after a request is taken
`timescale 1ns/10ps
module fur_loader_tb_top
    import fur_pkg::*;
();
    logic ref_clk;
    logic rst;
    logic ce;
    logic locked;
    fur_req_t cpu_req;
    fur_req_t dbg_req;
    fur_rsp_t cpu_rsp;
    fur_rsp_t dbg_rsp;
    fur_targets_t targets;
    logic exec_release;
    logic cfg_reserved;
    int mismatches;
    int n_tests;
    int seed;
    int n;
    int ra;
    int rb;
    int hold;
    logic [7:0] fuse_m [10];
    logic [7:0] row_m [ROW_BYTES];
    logic [7:0] live [10];
    logic [1:0] ae;
    logic [7:0] rd;
    logic [7:0] v;

    fur_loader dut (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .LOCKED(locked),
        .CPU_REQ(cpu_req), .CPU_RSP(cpu_rsp), .DBG_REQ(dbg_req), .DBG_RSP(dbg_rsp),
        .TARGETS(targets), .EXEC_RELEASE(exec_release), .CFG_RESERVED(cfg_reserved));
    fur_prog_model prog (.clk(ref_clk), .rsp(dbg_rsp), .req(dbg_req));
    fur_prog_model cpu (.clk(ref_clk), .rsp(cpu_rsp), .req(cpu_req));

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [7:0] rsv_mask(input int a);
        return (a == 2) ? 8'h0F : (a == 5) ? 8'hE9 : (a == 6) ? 8'h1F : 8'hFF;
    endfunction

    // fields pack in fuse bit order; upper oscillator bits unused
    function automatic logic [63:0] tgt_exp();
        return {12'h000, live[0], live[1], live[2][3:0], live[5], live[6], live[7], live[8]};
    endfunction

    function automatic logic rsv_exp();
        return live[1][7:5] > 3'h3 || live[1][1:0] == 2'h3 || live[2][3:0] > 4'h1;
    endfunction

    task automatic xfer(input logic dbg, input logic we, input logic row, input int a,
                        input logic [7:0] d, input logic [1:0] exp_ae);
        if (dbg)
            prog.access(we, row, 5'(a), d, $random(seed) & 3, ae, rd);
        else
            cpu.access(we, row, 5'(a), d, $random(seed) & 3, ae, rd);
        chk(dbg ? "dbg_ack_err" : "cpu_ack_err", exp_ae, ae);
    endtask

    task automatic do_reset();
        rst <= 1'h1;
        repeat (16) @(posedge ref_clk);
        chk("targets_in_reset", '0, targets);
        chk("release_in_reset", 0, exec_release);
        rst <= 1'h0;
        // enable held low for the first hold edges: the copy must freeze meanwhile
        ce <= (hold == 0);
        for (n = 1; n <= 20; n++) begin
            @(posedge ref_clk);
            if (n == hold)
                ce <= 1'h1;
            #1;
            if (exec_release === 1'h1)
                break;
        end
        chk("copy_edges", 9 + hold, n);
        if (n > 20)
            stop_test();
        live = fuse_m;
    endtask

    initial begin
        seed = 32'hF5BE;
        mismatches = 0;
        n_tests = 0;
        rst = 1'h1;
        ce = 1'h1;
        locked = 1'h0;
        hold = 0;
        do_reset();
        for (int r = 0; r < 8; r++) begin
            locked <= r[0];
            // every level and mode, and oscillator codes 0 to 2, come up over eight rounds
            for (int a = 0; a < 10; a++) begin
                v = 8'($random(seed));
                if (a == 1)
                    v = {r[2:0], r[0], r[1:0], r[1:0]};
                if (a == 2)
                    v = 8'(r % 3);
                if (a == 3 || a == 4 || a == 9) begin
                    xfer(1'h1, 1'h1, 1'h0, a, v, 2'h1);
                end else begin
                    xfer(1'h1, 1'h1, 1'h0, a, v, 2'h2);
                    fuse_m[a] = v & rsv_mask(a);
                end
            end
            if (r > 0)
                chk("targets_before_reset", tgt_exp(), targets);
            xfer(1'h0, 1'h1, 1'h0, 0, 8'h5A, 2'h1);
            xfer(1'h0, 1'h0, 1'h0, 0, 8'h00, 2'h2);
            chk("cpu_fuse_read", fuse_m[0], rd);
            xfer(1'h1, 1'h0, 1'h0, 8, 8'h00, r[0] ? 2'h1 : 2'h2);
            if (!r[0])
                chk("dbg_fuse_read", fuse_m[8], rd);
            ra = $random(seed) & 31;
            rb = (ra + 1) % 32;
            row_m[ra] = 8'($random(seed));
            row_m[rb] = 8'($random(seed));
            xfer(1'h0, 1'h1, 1'h1, ra, row_m[ra], 2'h2);
            xfer(1'h1, 1'h1, 1'h1, rb, row_m[rb], 2'h2);
            xfer(1'h1, 1'h0, 1'h1, ra, 8'h00, r[0] ? 2'h1 : 2'h2);
            if (!r[0])
                chk("dbg_row_read", row_m[ra], rd);
            hold = r % 4;
            do_reset();
            chk("targets", tgt_exp(), targets);
            chk("reserved_flag", rsv_exp(), cfg_reserved);
            xfer(1'h0, 1'h0, 1'h1, rb, 8'h00, 2'h2);
            chk("cpu_row_read", row_m[rb], rd);
            xfer(1'h0, 1'h0, 1'h0, 7, 8'h00, 2'h2);
            chk("fuse_kept", fuse_m[7], rd);
        end
        stop_test();
    end
endmodule
